/* rtl/timer_count_clock_select.sv */
// Counter clock source and edge selection for four timer channels.
`timescale 1ns/1ps

module timer_count_clock_select #(
	parameter int CNT_W = 16
) (
	input  wire logic                   clock,
	input  wire logic                   rst_b,
	input  wire tccs_pkg::tccs_apb_req_t apbReq,
	input  wire logic [3:0]             extClock,
	output      tccs_pkg::tccs_apb_rsp_t apbRsp,
	output      logic [3:0]             countEnable
);

	// ------------------------------------------------------------------
	// Parameter check
	// ------------------------------------------------------------------
	if (CNT_W < 2 || CNT_W > tccs_pkg::DATA_W) begin : g_bad_width
		$error("CNT_W must lie between 2 and the bus data width");
	end

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	typedef struct packed {
		logic [tccs_pkg::NUM_CH-1:0][7:0]       timer_control;
		logic [7:0]                             mode;
		logic [tccs_pkg::NUM_CH-1:0][CNT_W-1:0] cnt;
		logic [tccs_pkg::PSC_W-1:0]             psc;
		logic [tccs_pkg::PSC_W-1:0]             pscPrev;
		logic [tccs_pkg::NUM_EXT-1:0]           sync1;
		logic [tccs_pkg::NUM_EXT-1:0]           sync2;
		logic [tccs_pkg::NUM_EXT-1:0]           sync3;
		logic [tccs_pkg::NUM_EXT-1:0]           filt;
		logic [tccs_pkg::NUM_EXT-1:0]           extPrev;
		logic                                   ovf2;
		logic [tccs_pkg::NUM_CH-1:0]            countEnable;
		tccs_pkg::tccs_apb_rsp_t                rsp;
	} tccs_state_t;

	tccs_state_t                 st_r;
	tccs_state_t                 st_nxt;
	logic [tccs_pkg::NUM_CH-1:0] tick;
	logic [tccs_pkg::NUM_CH-1:0] phase;
	tccs_pkg::tccs_src_t         srcSel [tccs_pkg::NUM_CH];

	assign apbRsp = st_r.rsp;
	assign countEnable = st_r.countEnable;

	// ------------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------------
	always_comb begin
		logic hi;
		logic lo;
		logic up;
		logic wrap2;
		logic hit;
		int   pa;
		int   pb;
		hi = 1'b0;
		lo = 1'b0;
		up = 1'b1;
		wrap2 = 1'b0;
		hit = 1'b0;
		pa = 0;
		pb = 1;
		st_nxt = st_r;
		tick = '0;
		st_nxt.psc = st_r.psc + 1'b1;
		st_nxt.pscPrev = st_r.psc;
		// Pin synchroniser; a level is taken once stages two and three agree.
		st_nxt.sync1 = extClock;
		st_nxt.sync2 = st_r.sync1;
		st_nxt.sync3 = st_r.sync2;
		for (int i = 0; i < tccs_pkg::NUM_EXT; i++) begin
			if (st_r.sync2[i] == st_r.sync3[i])
				st_nxt.filt[i] = st_r.sync2[i];
		end
		st_nxt.extPrev = st_r.filt;
		phase = '0;
		phase[1] = st_r.mode[tccs_pkg::MODE_CH1_LSB+2 +: 2] ==
			tccs_pkg::PHASE_MD_HI;
		phase[2] = st_r.mode[tccs_pkg::MODE_CH2_LSB+2 +: 2] ==
			tccs_pkg::PHASE_MD_HI;

		for (int ch = 0; ch < tccs_pkg::NUM_CH; ch++) begin
			srcSel[ch] = tccs_pkg::srcOf(ch,
				st_r.timer_control[ch][tccs_pkg::PSC_MSB:0]);
			hi = st_r.timer_control[ch][tccs_pkg::EDGE_HI];
			lo = st_r.timer_control[ch][tccs_pkg::EDGE_LO];
			if (srcSel[ch] == tccs_pkg::SRC_DIV1 ||
				srcSel[ch] == tccs_pkg::SRC_CHAIN) begin
				hi = 1'b0;
				lo = 1'b0;
			end
			up = 1'b1;
			case (srcSel[ch])
				tccs_pkg::SRC_DIV1: tick[ch] = 1'b1;
				tccs_pkg::SRC_DIV4: tick[ch] = tccs_pkg::edgeHit(
					st_r.pscPrev[tccs_pkg::DIV4_BIT],
					st_r.psc[tccs_pkg::DIV4_BIT], hi, lo);
				tccs_pkg::SRC_DIV16: tick[ch] = tccs_pkg::edgeHit(
					st_r.pscPrev[tccs_pkg::DIV16_BIT],
					st_r.psc[tccs_pkg::DIV16_BIT], hi, lo);
				tccs_pkg::SRC_DIV64: tick[ch] = tccs_pkg::edgeHit(
					st_r.pscPrev[tccs_pkg::DIV64_BIT],
					st_r.psc[tccs_pkg::DIV64_BIT], hi, lo);
				tccs_pkg::SRC_DIV256: tick[ch] = tccs_pkg::edgeHit(
					st_r.pscPrev[tccs_pkg::DIV256_BIT],
					st_r.psc[tccs_pkg::DIV256_BIT], hi, lo);
				tccs_pkg::SRC_DIV1024: tick[ch] = tccs_pkg::edgeHit(
					st_r.pscPrev[tccs_pkg::DIV1024_BIT],
					st_r.psc[tccs_pkg::DIV1024_BIT], hi, lo);
				tccs_pkg::SRC_EXTA: tick[ch] = tccs_pkg::edgeHit(
					st_r.extPrev[0], st_r.filt[0], hi, lo);
				tccs_pkg::SRC_EXTB: tick[ch] = tccs_pkg::edgeHit(
					st_r.extPrev[1], st_r.filt[1], hi, lo);
				tccs_pkg::SRC_EXTC: tick[ch] = tccs_pkg::edgeHit(
					st_r.extPrev[2], st_r.filt[2], hi, lo);
				tccs_pkg::SRC_EXTD: tick[ch] = tccs_pkg::edgeHit(
					st_r.extPrev[3], st_r.filt[3], hi, lo);
				tccs_pkg::SRC_CHAIN: tick[ch] = st_r.ovf2;
				default: tick[ch] = 1'b0;
			endcase
			// Phase counting follows a quadrature pin pair and overrides both
			// the source field and the edge bits.
			if (phase[ch]) begin
				pa = (ch == 1) ? 0 : 2;
				pb = pa + 1;
				tick[ch] = (st_r.filt[pa] != st_r.extPrev[pa]) ||
					(st_r.filt[pb] != st_r.extPrev[pb]);
				up = st_r.filt[pa] ^ st_r.extPrev[pb];
			end
			if (tick[ch]) begin
				if (ch == 2)
					wrap2 = up ? (&st_r.cnt[ch]) : (~|st_r.cnt[ch]);
				st_nxt.cnt[ch] = up ? st_r.cnt[ch] + 1'b1 : st_r.cnt[ch] - 1'b1;
			end
		end
		st_nxt.ovf2 = wrap2;
		st_nxt.countEnable = tick;

		// APB: the setup cycle prepares the answer, the access edge commits.
		st_nxt.rsp.pready = 1'b0;
		if (apbReq.psel && !apbReq.penable) begin
			st_nxt.rsp.pready = 1'b1;
			st_nxt.rsp.pslverr = 1'b1;
			st_nxt.rsp.prdata = '0;
			if (apbReq.paddr == tccs_pkg::OFS_MODE) begin
				st_nxt.rsp.pslverr = 1'b0;
				st_nxt.rsp.prdata[7:0] = st_r.mode;
			end
			for (int ch = 0; ch < tccs_pkg::NUM_CH; ch++) begin
				if (apbReq.paddr == tccs_pkg::addrOf(tccs_pkg::OFS_CTRL_BASE, ch))
				begin
					st_nxt.rsp.pslverr = 1'b0;
					st_nxt.rsp.prdata[7:0] = st_r.timer_control[ch];
				end
				if (apbReq.paddr == tccs_pkg::addrOf(tccs_pkg::OFS_CNT_BASE, ch))
				begin
					st_nxt.rsp.pslverr = 1'b0;
					st_nxt.rsp.prdata[CNT_W-1:0] = st_r.cnt[ch];
				end
			end
		end
		if (apbReq.psel && apbReq.penable && st_r.rsp.pready &&
			apbReq.pwrite && !st_r.rsp.pslverr) begin
			hit = apbReq.paddr == tccs_pkg::OFS_MODE;
			if (hit)
				st_nxt.mode = apbReq.pwdata[7:0];
			for (int ch = 0; ch < tccs_pkg::NUM_CH; ch++) begin
				if (apbReq.paddr == tccs_pkg::addrOf(tccs_pkg::OFS_CTRL_BASE, ch))
					st_nxt.timer_control[ch] = apbReq.pwdata[7:0] &
						((ch == 1 || ch == 2) ? tccs_pkg::CTRL_MASK_NARROW :
						tccs_pkg::CTRL_MASK_WIDE);
				if (apbReq.paddr == tccs_pkg::addrOf(tccs_pkg::OFS_CNT_BASE, ch))
					st_nxt.cnt[ch] = apbReq.pwdata[CNT_W-1:0];
			end
		end
	end

	// ------------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------------
	// Every reset value of this block is zero.
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	chk_rising_edge: assert property (
		@(posedge clock) disable iff (!rst_b)
		(srcSel[0] == tccs_pkg::SRC_DIV4 && st_r.timer_control[0][4:3] == 2'b00 &&
		tick[0]) |-> (!st_r.pscPrev[1] && st_r.psc[1]))
		else $error("rising edge select counted a wrong edge");

	chk_falling_edge: assert property (
		@(posedge clock) disable iff (!rst_b)
		(srcSel[0] == tccs_pkg::SRC_DIV4 && st_r.timer_control[0][4:3] == 2'b01 &&
		tick[0]) |-> (st_r.pscPrev[1] && !st_r.psc[1]))
		else $error("falling edge select counted a wrong edge");

	chk_both_edges: assert property (
		@(posedge clock) disable iff (!rst_b)
		(srcSel[0] == tccs_pkg::SRC_DIV16 && st_r.timer_control[0][4]) |->
		(tick[0] == (st_r.pscPrev[3] != st_r.psc[3])))
		else $error("both edge select missed an edge");

	chk_undivided_rising: assert property (
		@(posedge clock) disable iff (!rst_b)
		(srcSel[0] == tccs_pkg::SRC_DIV1) |-> tick[0])
		else $error("undivided source failed to count every cycle");

	chk_chain_rising: assert property (
		@(posedge clock) disable iff (!rst_b)
		(srcSel[1] == tccs_pkg::SRC_CHAIN && !phase[1]) |->
		(tick[1] == st_r.ovf2))
		else $error("chained source did not follow the wrap event");

	chk_independent_src: assert property (
		@(posedge clock) disable iff (!rst_b)
		(st_r.timer_control[0][2:0] == 3'h4 && st_r.timer_control[3][2:0] == 3'h4) |->
		(srcSel[0] == tccs_pkg::SRC_EXTA &&
		srcSel[3] == tccs_pkg::SRC_DIV256))
		else $error("channel sources are not independent");

	chk_ch0_decode: assert property (
		@(posedge clock) disable iff (!rst_b)
		(st_r.timer_control[0][2:0] == 3'h7) |-> (srcSel[0] == tccs_pkg::SRC_EXTD))
		else $error("channel 0 code 7 not mapped to pin D");

	chk_ch1_decode: assert property (
		@(posedge clock) disable iff (!rst_b)
		(st_r.timer_control[1][2:0] == 3'h6) |-> (srcSel[1] == tccs_pkg::SRC_DIV256))
		else $error("channel 1 code 6 not mapped to divide by 256");

	chk_ch2_decode: assert property (
		@(posedge clock) disable iff (!rst_b)
		(st_r.timer_control[2][2:0] == 3'h7) |-> (srcSel[2] == tccs_pkg::SRC_DIV1024))
		else $error("channel 2 code 7 not mapped to divide by 1024");

	chk_ch3_decode: assert property (
		@(posedge clock) disable iff (!rst_b)
		(st_r.timer_control[3][2:0] == 3'h5) |-> (srcSel[3] == tccs_pkg::SRC_DIV1024))
		else $error("channel 3 code 5 not mapped to divide by 1024");

	chk_ch1_phase_ignore: assert property (
		@(posedge clock) disable iff (!rst_b)
		(phase[1] && st_r.filt[1:0] == st_r.extPrev[1:0]) |-> !tick[1])
		else $error("channel 1 counted from its source in phase mode");

	chk_ch2_phase_ignore: assert property (
		@(posedge clock) disable iff (!rst_b)
		(phase[2] && st_r.filt[3:2] == st_r.extPrev[3:2]) |-> !tick[2])
		else $error("channel 2 counted from its source in phase mode");

	chk_reset_source: assert property (
		@(posedge clock)
		$rose(rst_b) |-> (st_r.timer_control == {tccs_pkg::NUM_CH{tccs_pkg::CTRL_RESET}}
		&& srcSel[0] == tccs_pkg::SRC_DIV1))
		else $error("source field not zero after reset");

	chk_double_rate: assert property (
		@(posedge clock) disable iff (!rst_b)
		(srcSel[0] == tccs_pkg::SRC_DIV4 && st_r.timer_control[0][4] && tick[0]) |->
		##2 (tick[0] || st_r.timer_control[0] != $past(st_r.timer_control[0], 2)))
		else $error("both edges of divide by 4 did not count every 2 cycles");

	chk_ext_single_pulse: assert property (
		@(posedge clock) disable iff (!rst_b)
		(tick[0] && srcSel[0] == tccs_pkg::SRC_EXTA) |=>
		(!tick[0] || srcSel[0] != tccs_pkg::SRC_EXTA))
		else $error("pin edge gave a count enable longer than one cycle");

	chk_enable_output: assert property (
		@(posedge clock) disable iff (!rst_b)
		tick[0] |=> countEnable[0])
		else $error("count enable output did not follow the tick");

	chk_falling_pin: assert property (
		@(posedge clock) disable iff (!rst_b)
		(srcSel[0] == tccs_pkg::SRC_EXTA && st_r.timer_control[0][4:3] == 2'b01 &&
		tick[0]) |-> (st_r.extPrev[0] && !st_r.filt[0]))
		else $error("falling edge select counted a rising pin edge");

	chk_ch0_pin_a: assert property (
		@(posedge clock) disable iff (!rst_b)
		(st_r.timer_control[0][2:0] == 3'h4) |-> (srcSel[0] == tccs_pkg::SRC_EXTA))
		else $error("channel 0 code 4 not mapped to pin A");

	chk_ch1_chain_code: assert property (
		@(posedge clock) disable iff (!rst_b)
		(st_r.timer_control[1][2:0] == 3'h7) |-> (srcSel[1] == tccs_pkg::SRC_CHAIN))
		else $error("channel 1 code 7 not mapped to the channel 2 wrap");

	chk_ch2_pin_c: assert property (
		@(posedge clock) disable iff (!rst_b)
		(st_r.timer_control[2][2:0] == 3'h6) |-> (srcSel[2] == tccs_pkg::SRC_EXTC))
		else $error("channel 2 code 6 not mapped to pin C");

	chk_ch3_pin_a: assert property (
		@(posedge clock) disable iff (!rst_b)
		(st_r.timer_control[3][2:0] == 3'h6) |-> (srcSel[3] == tccs_pkg::SRC_EXTA))
		else $error("channel 3 code 6 not mapped to pin A");

	chk_phase_any_edge: assert property (
		@(posedge clock) disable iff (!rst_b)
		(phase[1] && st_r.filt[0] != st_r.extPrev[0]) |-> tick[1])
		else $error("phase mode channel 1 missed a pin edge");

	chk_filter_hold: assert property (
		@(posedge clock) disable iff (!rst_b)
		(st_r.sync2[0] != st_r.sync3[0]) |=> $stable(st_r.filt[0]))
		else $error("pin filter took a level before two stages agreed");

	cov_both_edges: cover property (@(posedge clock) disable iff (!rst_b)
		srcSel[0] == tccs_pkg::SRC_DIV4 && st_r.timer_control[0][4] && tick[0]);
	cov_chain_tick: cover property (@(posedge clock) disable iff (!rst_b)
		srcSel[1] == tccs_pkg::SRC_CHAIN && tick[1]);
	cov_phase_tick: cover property (@(posedge clock) disable iff (!rst_b)
		phase[1] && tick[1]);
	cov_ext_tick: cover property (@(posedge clock) disable iff (!rst_b)
		srcSel[0] == tccs_pkg::SRC_EXTA && tick[0]);

endmodule // timer_count_clock_select

/* rtl/tccs_pkg.sv */
// Constants, types and decode helpers for the timer clock select block.
package tccs_pkg;

	// ------------------------------------------------------------------
	// Sizes
	// ------------------------------------------------------------------
	localparam int NUM_CH = 4;
	localparam int NUM_EXT = 4;
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;
	localparam int PSC_W = 10;

	// ------------------------------------------------------------------
	// Register map and fields
	// ------------------------------------------------------------------
	localparam logic [ADDR_W-1:0] OFS_CTRL_BASE = 12'h000;
	localparam logic [ADDR_W-1:0] OFS_MODE = 12'h010;
	localparam logic [ADDR_W-1:0] OFS_CNT_BASE = 12'h020;
	localparam logic [ADDR_W-1:0] REG_STRIDE = 12'h004;
	localparam int EDGE_HI = 4;
	localparam int EDGE_LO = 3;
	localparam int PSC_MSB = 2;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [7:0] MODE_RESET = 8'h00;
	localparam logic [7:0] CTRL_MASK_WIDE = 8'hFF;
	localparam logic [7:0] CTRL_MASK_NARROW = 8'h7F;
	localparam int MODE_CH1_LSB = 0;
	localparam int MODE_CH2_LSB = 4;
	localparam logic [1:0] PHASE_MD_HI = 2'h1;

	// ------------------------------------------------------------------
	// Prescaler tap bits: bit k toggles every 2^k cycles
	// ------------------------------------------------------------------
	localparam int DIV4_BIT = 1;
	localparam int DIV16_BIT = 3;
	localparam int DIV64_BIT = 5;
	localparam int DIV256_BIT = 7;
	localparam int DIV1024_BIT = 9;

	typedef enum logic [3:0] {
		SRC_DIV1, SRC_DIV4, SRC_DIV16, SRC_DIV64, SRC_DIV256, SRC_DIV1024,
		SRC_EXTA, SRC_EXTB, SRC_EXTC, SRC_EXTD, SRC_CHAIN
	} tccs_src_t;

	typedef struct packed {
		logic              psel;
		logic              penable;
		logic              pwrite;
		logic [ADDR_W-1:0] paddr;
		logic [DATA_W-1:0] pwdata;
	} tccs_apb_req_t;

	typedef struct packed {
		logic              pready;
		logic              pslverr;
		logic [DATA_W-1:0] prdata;
	} tccs_apb_rsp_t;

	function automatic logic [ADDR_W-1:0] addrOf(
		input logic [ADDR_W-1:0] base, input int ch);
		return base + REG_STRIDE * ADDR_W'(ch);
	endfunction

	function automatic tccs_src_t srcOf(input int ch, input logic [2:0] code);
		tccs_src_t s;
		s = SRC_DIV1;
		case (code)
			3'h0: s = SRC_DIV1;
			3'h1: s = SRC_DIV4;
			3'h2: s = SRC_DIV16;
			3'h3: s = SRC_DIV64;
			3'h4: s = (ch == 3) ? SRC_DIV256 : SRC_EXTA;
			3'h5: s = (ch == 3) ? SRC_DIV1024 : SRC_EXTB;
			3'h6: s = (ch == 1) ? SRC_DIV256 : (ch == 3) ? SRC_EXTA : SRC_EXTC;
			3'h7: s = (ch == 0) ? SRC_EXTD : (ch == 1) ? SRC_CHAIN :
				(ch == 2) ? SRC_DIV1024 : SRC_EXTB;
		endcase
		return s;
	endfunction

	function automatic logic edgeHit(input logic prev, input logic cur,
		input logic hi, input logic lo);
		if (hi)
			return prev != cur;
		else if (lo)
			return prev && !cur;
		return !prev && cur;
	endfunction

endpackage

/* testbench/tccs_pin_model.sv */
// Behavioural model of the four external clock pins that feed the timer.
`timescale 1ns/1ps

module tccs_pin_model (
	input  wire logic       clock,
	output      logic [3:0] extClock
);

	initial extClock = 4'h0;

	// Drives one pin to a level just after a rising edge and then holds it.
	task automatic setPin(input int k, input logic v);
		@(posedge clock);
		extClock[k] <= v;
	endtask

	// Pin k toggles every 2+k cycles for 3+2k periods, then rests low.
	// Each level is held at least two cycles so that no edge is filtered.
	task automatic burst();
		for (int t = 0; t < 96; t++) begin
			@(posedge clock);
			for (int k = 0; k < 4; k++) begin
				extClock[k] <= (t < 2 * (2 + k) * (3 + 2 * k))
					&& ((t / (2 + k)) % 2 == 1);
			end
		end
	endtask

endmodule // tccs_pin_model

/* testbench/timer_count_clock_select_test.sv */
// Self-checking testbench for the timer clock select block.
`timescale 1ns/1ps

module timer_count_clock_select_test;

	localparam int WIN = 1024;
	// Per channel and code: a divider, -1 to -4 for pins A to D, 0 for chain.
	localparam int SRC_TBL [4][8] = '{
		'{1, 4, 16, 64, -1, -2, -3, -4},
		'{1, 4, 16, 64, -1, -2, 256, 0},
		'{1, 4, 16, 64, -1, -2, -3, 1024},
		'{1, 4, 16, 64, 256, 1024, -1, -2}};
	localparam int RISE [4] = '{1, 0, 1, 1};
	localparam int FALL [4] = '{0, 1, 1, 1};

	logic                    clock;
	logic                    rst_b;
	tccs_pkg::tccs_apb_req_t apbReq;
	tccs_pkg::tccs_apb_rsp_t apbRsp;
	logic [3:0]              extClock;
	logic [3:0]              countEnable;
	int                      errTotal;
	int                      nChecks;

	timer_count_clock_select dut (
		.clock       (clock),
		.rst_b       (rst_b),
		.apbReq      (apbReq),
		.extClock    (extClock),
		.apbRsp      (apbRsp),
		.countEnable (countEnable)
	);

	tccs_pin_model pins (
		.clock    (clock),
		.extClock (extClock)
	);

	initial begin
		clock = 1'h0;
		forever #4 clock = ~clock;
	end

	// ------------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------------
	task automatic completeRun();
		$display("checks %0d mismatches %0d", nChecks, errTotal);
		if (errTotal == 0 && nChecks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		nChecks++;
		if (seen !== exp) begin
			errTotal++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic apb(input logic wr, input logic [11:0] addr,
		input logic [31:0] wd, output logic [31:0] rd, output logic err);
		@(posedge clock);
		apbReq.psel <= 1'h1;
		apbReq.penable <= 1'h0;
		apbReq.pwrite <= wr;
		apbReq.paddr <= addr;
		apbReq.pwdata <= wd;
		@(posedge clock);
		apbReq.penable <= 1'h1;
		do begin
			@(posedge clock);
		end while (apbRsp.pready !== 1'h1);
		rd = apbRsp.prdata;
		err = apbRsp.pslverr;
		apbReq.psel <= 1'h0;
		apbReq.penable <= 1'h0;
	endtask

	task automatic regWr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic        e;
		apb(1'h1, a, d, r, e);
	endtask

	task automatic countPulses(input int ch, input int len, output int n);
		n = 0;
		repeat (len) begin
			@(posedge clock);
			if (countEnable[ch] === 1'h1) n++;
		end
	endtask

	// Selects a source and edge mode, then counts over one window.
	task automatic rateTest(input int ch, input int code, input logic [1:0] em,
		input int exp);
		int n;
		regWr(tccs_pkg::OFS_CTRL_BASE + 12'(4 * ch), {27'h0, em, 3'(code)});
		if (ch == 1 && code == 7) regWr(tccs_pkg::OFS_CNT_BASE + 12'h8, 32'hFFF0);
		repeat (8) @(posedge clock);
		fork
			pins.burst();
			countPulses(ch, WIN, n);
		join
		check(32'(n), 32'(exp));
	endtask

	// ------------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------------
	initial begin
		int          n;
		int          d;
		int          ex;
		logic [31:0] rd;
		logic        e;
		apbReq = '0;
		rst_b = 1'h0;
		errTotal = 0;
		nChecks = 0;
		repeat (4) @(posedge clock);
		rst_b <= 1'h1;
		@(posedge clock);
		for (int ch = 0; ch < 4; ch++) begin
			countPulses(ch, 16, n);
			check(32'(n), 32'h10);
			apb(1'h0, tccs_pkg::OFS_CTRL_BASE + 12'(4 * ch), 32'h0, rd, e);
			check(rd, 32'h0);
		end
		regWr(tccs_pkg::OFS_CTRL_BASE, 32'hFFFFFFFF);
		apb(1'h0, tccs_pkg::OFS_CTRL_BASE, 32'h0, rd, e);
		check(rd, 32'hFF);
		regWr(tccs_pkg::OFS_CTRL_BASE + 12'h4, 32'hFF);
		apb(1'h0, tccs_pkg::OFS_CTRL_BASE + 12'h4, 32'h0, rd, e);
		check(rd, 32'h7F);
		apb(1'h0, 12'h100, 32'h0, rd, e);
		check({rd[30:0], e}, 32'h1);
		for (int ch = 0; ch < 4; ch++) begin
			for (int c = 0; c < 8; c++) begin
				d = SRC_TBL[ch][c];
				if (d > 1) ex = 2 * WIN / d;
				else if (d == 1) ex = WIN;
				else if (d < 0) ex = 2 * (1 - 2 * d);
				else ex = 1;
				rateTest(ch, c, 2'h3, ex);
			end
		end
		for (int ch = 0; ch < 4; ch++) begin
			apb(1'h0, tccs_pkg::OFS_CTRL_BASE + 12'(4 * ch), 32'h0, rd, e);
			check(rd, 32'h1F);
		end
		rateTest(3, 5, 2'h0, WIN / 1024);
		rateTest(3, 2, 2'h2, 2 * WIN / 16);
		rateTest(0, 0, 2'h1, WIN);
		rateTest(0, 1, 2'h0, WIN / 4);
		rateTest(0, 1, 2'h1, WIN / 4);
		for (int em = 0; em < 4; em++) begin
			regWr(tccs_pkg::OFS_CTRL_BASE, {27'h0, 2'(em), 3'h4});
			repeat (8) @(posedge clock);
			fork
				pins.setPin(0, 1'h1);
				countPulses(0, 20, n);
			join
			check(32'(n), 32'(RISE[em]));
			fork
				pins.setPin(0, 1'h0);
				countPulses(0, 20, n);
			join
			check(32'(n), 32'(FALL[em]));
		end
		rateTest(3, 4, 2'h0, WIN / 256);
		regWr(tccs_pkg::OFS_MODE, 32'h44);
		regWr(tccs_pkg::OFS_CTRL_BASE + 12'h4, 32'h08);
		regWr(tccs_pkg::OFS_CTRL_BASE + 12'h8, 32'h08);
		repeat (8) @(posedge clock);
		countPulses(1, 64, n);
		check(32'(n), 32'h0);
		countPulses(2, 64, n);
		check(32'(n), 32'h0);
		apb(1'h0, tccs_pkg::OFS_CNT_BASE + 12'h4, 32'h0, rd, e);
		ex = int'(rd) + 1;
		fork
			pins.setPin(0, 1'h1);
			countPulses(1, 20, n);
		join
		check(32'(n), 32'h1);
		apb(1'h0, tccs_pkg::OFS_CNT_BASE + 12'h4, 32'h0, rd, e);
		check(rd, 32'(ex) & 32'hFFFF);
		fork
			pins.setPin(2, 1'h1);
			countPulses(2, 20, n);
		join
		check(32'(n), 32'h1);
		regWr(tccs_pkg::OFS_MODE, 32'h0);
		completeRun();
	end

	initial begin
		repeat (80000) @(posedge clock);
		errTotal++;
		$display("mismatch at %0t: run did not finish in time", $time);
		completeRun();
	end

endmodule // timer_count_clock_select_test
